// ==== hw/wdt_map.svh ====
`ifndef WDT_MAP_SVH
`define WDT_MAP_SVH
// ==========================================
// Register offsets (byte addresses)
`define CTRL_OFF        12'h000
`define STATUS_OFF      12'h004
`define INT_STAT_OFF    12'h008
`define INT_MASK_OFF    12'h00C
// ==========================================
// CTRL fields
`define CTRL_LATCH_BIT  0
`define CTRL_CLEAR_BIT  1
`define CTRL_RESET      32'h0000_0000
// ==========================================
// Interrupt status fields
`define IRQ_TIMEOUT_BIT 0
`define IRQ_MANUAL_BIT  1
`define IRQ_WIDTH       2
// ==========================================
// Timing, in microseconds, and the clock rate
`define CLK_MHZ         40
`define TIMEOUT_US      1000
`define ASSERT_US       2000
`define STARTUP_US      0
`endif

// ==== hw/wdt_pkg.sv ====
package wdt_pkg;
    typedef enum logic [1:0] {
        ST_STARTUP,
        ST_MONITOR,
        ST_ASSERT,
        ST_LATCHED
    } wdt_state_t;

    typedef logic [1:0] scale_sel_t;
endpackage

// ==== hw/wdt_in_if.sv ====
`timescale 1ns/10ps
interface wdt_in_if;
    logic kick_fall;
    logic manual_low;
    logic enable_lvl;
    logic [1:0] scale_sel;
    modport producer (output kick_fall, output manual_low, output enable_lvl, output scale_sel);
    modport consumer (input kick_fall, input manual_low, input enable_lvl, input scale_sel);
endinterface

// ==== hw/wdt_input_cond.sv ====
`timescale 1ns/10ps
module wdt_input_cond
    import wdt_pkg::*;
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       kick_in,
    input  wire logic       manual_assert_n,
    input  wire logic       monitor_enable_in,
    input  wire logic       scale_sel_0,
    input  wire logic       scale_sel_1,
    wdt_in_if.producer      sig
);
    logic [1:0] kick_q;
    logic       man_q;
    logic       en_q;
    logic [1:0] sel_q;

    // ==========================================
    // Register pins and detect kick falling edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            kick_q <= 2'h3;
            man_q  <= 1'b1;
            en_q   <= 1'b0;
            sel_q  <= 2'h0;
        end else begin
            kick_q <= {kick_q[0], kick_in};
            man_q  <= manual_assert_n;
            en_q   <= monitor_enable_in;
            sel_q  <= {scale_sel_1, scale_sel_0};
        end
    end

    assign sig.kick_fall  = kick_q[1] & ~kick_q[0];
    assign sig.manual_low = ~man_q;
    assign sig.enable_lvl = en_q;
    assign sig.scale_sel  = sel_q;
endmodule

// ==== hw/wdt_irq.sv ====
`timescale 1ns/10ps
`include "wdt_map.svh"
module wdt_irq
    import wdt_pkg::*;
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic [`IRQ_WIDTH-1:0] event_in,
    input  wire logic [`IRQ_WIDTH-1:0] clear_in,
    input  wire logic [`IRQ_WIDTH-1:0] mask_in,
    output logic      [`IRQ_WIDTH-1:0] status_q,
    output logic                       irq_q
);
    // ==========================================
    // Sticky status: a new event beats a clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~clear_in) | event_in;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(((status_q & ~clear_in) | event_in) & mask_in);
        end
    end
endmodule

// ==== hw/timeout_watchdog_timer.sv ====
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/10ps
`include "wdt_map.svh"
// Overview of operation
// - Kick falling edge restarts timeout count
// - Timeout without kick asserts fault output
// - Manual low asserts fault unconditionally
// - Monitor only while enable input high
// - Scale code 11 also disables monitoring
// - Timeout multiplied 1X to 256X
// - Scale changes apply on the fly
// - Optional startup delay suppresses monitoring
// - Latched mode holds fault until cleared
// - Base timeout preset at build time
// - Assert period preset at build time
// - Fault output is active low
module timeout_watchdog_timer
    import wdt_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYC = `TIMEOUT_US * `CLK_MHZ,
    parameter int unsigned ASSERT_CYC  = `ASSERT_US * `CLK_MHZ,
    parameter int unsigned STARTUP_CYC = `STARTUP_US * `CLK_MHZ
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        kick_in,
    input  wire logic        manual_assert_n,
    input  wire logic        monitor_enable_in,
    input  wire logic        scale_sel_0,
    input  wire logic        scale_sel_1,
    output logic             fault_out_n,
    output logic             irq
);
    import wdt_pkg::*;

    // ==========================================
    // Input conditioning
    wdt_in_if sig ();

    wdt_input_cond u_cond (
        .hclk              (hclk),
        .hresetn           (hresetn),
        .kick_in           (kick_in),
        .manual_assert_n   (manual_assert_n),
        .monitor_enable_in (monitor_enable_in),
        .scale_sel_0       (scale_sel_0),
        .scale_sel_1       (scale_sel_1),
        .sig               (sig.producer)
    );

    // Multiplier per scale code; code 11 is the disable code
    function automatic logic [8:0] scale_mult(input scale_sel_t s);
        case (s)
            2'h0:    scale_mult = 9'h001;
            2'h1:    scale_mult = 9'h004;
            2'h2:    scale_mult = 9'h100;
            default: scale_mult = 9'h001;
        endcase
    endfunction

    // ==========================================
    // AHB-Lite slave
    logic        ctrl_latch_q;
    logic        wr_pend_q;
    logic [11:0] addr_q;
    logic        ahb_go;
    logic [`IRQ_WIDTH-1:0] mask_q;
    logic [`IRQ_WIDTH-1:0] int_stat;
    logic [`IRQ_WIDTH-1:0] int_clr;
    logic        fault_clear;
    logic        irq_w;
    wdt_state_t  state_q;

    assign ahb_go = hsel & hready & htrans[1];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            addr_q    <= 12'h000;
        end else begin
            wr_pend_q <= ahb_go & hwrite;
            if (ahb_go) begin
                addr_q <= haddr[11:0];
            end
        end
    end

    // Clear strobe and status-clear write only last one cycle
    assign fault_clear = wr_pend_q & (addr_q == `CTRL_OFF) & hwdata[`CTRL_CLEAR_BIT];
    assign int_clr     = (wr_pend_q & (addr_q == `INT_STAT_OFF)) ? hwdata[`IRQ_WIDTH-1:0] : '0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_latch_q <= 1'b0;
            mask_q       <= '0;
        end else if (wr_pend_q) begin
            if (addr_q == `CTRL_OFF) begin
                ctrl_latch_q <= hwdata[`CTRL_LATCH_BIT];
            end
            if (addr_q == `INT_MASK_OFF) begin
                mask_q <= hwdata[`IRQ_WIDTH-1:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ahb_go & ~hwrite) begin
            case (haddr[11:0])
                `CTRL_OFF:     hrdata <= {31'h0, ctrl_latch_q};
                `STATUS_OFF:   hrdata <= {27'h0, sig.scale_sel, state_q, ~fault_out_n};
                `INT_STAT_OFF: hrdata <= {30'h0, int_stat};
                `INT_MASK_OFF: hrdata <= {30'h0, mask_q};
                default:       hrdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // ==========================================
    // Watchdog core
    logic [39:0] cnt_q;
    logic [39:0] limit;
    logic        mon_on;
    logic        expired;
    logic        timeout_ev;

    assign mon_on  = sig.enable_lvl & (sig.scale_sel != 2'h3);
    // Limit recomputed every cycle so a new scale takes effect at once
    assign limit   = 40'(TIMEOUT_CYC) * 40'(scale_mult(sig.scale_sel));
    assign expired = mon_on & (cnt_q >= limit - 40'h1);
    assign timeout_ev = (state_q == ST_MONITOR) & expired & ~sig.kick_fall;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_STARTUP;
            cnt_q   <= 40'h0;
        end else begin
            case (state_q)
                ST_STARTUP: begin
                    // Startup window ignores timeouts entirely
                    if (cnt_q >= 40'(STARTUP_CYC)) begin
                        state_q <= ST_MONITOR;
                        cnt_q   <= 40'h0;
                    end else begin
                        cnt_q <= cnt_q + 40'h1;
                    end
                end
                ST_MONITOR: begin
                    if (sig.kick_fall | ~mon_on) begin
                        cnt_q <= 40'h0;
                    end else if (expired) begin
                        cnt_q   <= 40'h0;
                        state_q <= ctrl_latch_q ? ST_LATCHED : ST_ASSERT;
                    end else begin
                        cnt_q <= cnt_q + 40'h1;
                    end
                end
                ST_ASSERT: begin
                    if (cnt_q >= 40'(ASSERT_CYC) - 40'h1) begin
                        cnt_q   <= 40'h0;
                        state_q <= ST_MONITOR;
                    end else begin
                        cnt_q <= cnt_q + 40'h1;
                    end
                end
                ST_LATCHED: begin
                    if (fault_clear) begin
                        cnt_q   <= 40'h0;
                        state_q <= ST_MONITOR;
                    end
                end
                default: begin
                    state_q <= ST_STARTUP;
                    cnt_q   <= 40'h0;
                end
            endcase
        end
    end

    // ==========================================
    // Fault output
    logic fault_d;
    assign fault_d = sig.manual_low
                   | (state_q == ST_ASSERT) | (state_q == ST_LATCHED) | timeout_ev;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_out_n <= 1'b1;
        end else begin
            fault_out_n <= ~fault_d;
        end
    end

    // ==========================================
    // Interrupts
    wdt_irq u_irq (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .event_in ({sig.manual_low, timeout_ev}),
        .clear_in (int_clr),
        .mask_in  (mask_q),
        .status_q (int_stat),
        .irq_q    (irq_w)
    );
    assign irq = irq_w;

    // ==========================================
    // Checks
    manual_fault_a: assert property (@(posedge hclk) disable iff (!hresetn)
        sig.manual_low |=> !fault_out_n) else $error("manual low did not assert fault");
    timeout_fault_a: assert property (@(posedge hclk) disable iff (!hresetn)
        timeout_ev |=> !fault_out_n) else $error("timeout did not assert fault");
    kick_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_q == ST_MONITOR && sig.kick_fall) |=> cnt_q == 40'h0) else $error("kick did not restart");
    disabled_quiet_a: assert property (@(posedge hclk) disable iff (!hresetn)
        !mon_on |-> !timeout_ev) else $error("timeout while disabled");
    code3_off_a: assert property (@(posedge hclk) disable iff (!hresetn)
        sig.scale_sel == 2'h3 |-> !mon_on) else $error("scale code 3 left monitor on");
    latch_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_q == ST_LATCHED && !fault_clear) |=> state_q == ST_LATCHED) else $error("latch lost");
    assert_release_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(state_q == ST_ASSERT) |-> state_q == ST_MONITOR && cnt_q == 40'h0)
        else $error("bad release after assert period");
    scale_limit_a: assert property (@(posedge hclk) disable iff (!hresetn)
        sig.scale_sel == 2'h2 |-> limit == 40'(TIMEOUT_CYC) * 40'h100) else $error("256X limit wrong");
    mon_no_fault_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (state_q == ST_MONITOR && !timeout_ev && !sig.manual_low) |=> fault_out_n)
        else $error("spurious fault");
endmodule

// ==== tb/host_model.sv ====
`timescale 1ns/10ps
// ==========================================
// Host that kicks the watchdog
module host_model (
    input  wire logic hclk,
    input  wire logic fault_out_n,
    input  int        period,
    output logic      kick_in,
    output int        resets
);
    int   cnt;
    logic fault_d;
    initial begin
        cnt = 0;
        fault_d = 1'b1;
        kick_in = 1'b1;
        resets = 0;
    end
    // Period 0 parks the line high, so no stray fall passes for a kick
    always @(posedge hclk) begin
        cnt <= (cnt + 1 >= period) ? 0 : cnt + 1;
        kick_in <= (period == 0) || (cnt < period / 2);
    end
    always @(negedge hclk) begin
        fault_d <= fault_out_n;
        if (fault_d && !fault_out_n) resets <= resets + 1;
    end
endmodule

// ==== tb/timeout_watchdog_timer_tb_top.sv ====
`timescale 1ns/10ps
`include "wdt_map.svh"
module timeout_watchdog_timer_tb_top;
    import wdt_pkg::*;
    localparam int TO = 20;
    localparam int AS = 10;
    localparam int SU = 5;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = '0;
    logic [1:0]  htrans = '0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = '0;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        kick_in;
    logic        manual_assert_n = 1'b1;
    logic        en = 1'b1;
    scale_sel_t  scl = '0;
    logic        fault_out_n;
    logic        irq;
    logic [31:0] rd;
    int          period = 0;
    int          resets;
    int          n;
    int          r0;
    int          mismatches = 0;
    int          compares = 0;

    always #12.5 hclk = ~hclk;

    timeout_watchdog_timer #(.TIMEOUT_CYC(TO), .ASSERT_CYC(AS), .STARTUP_CYC(SU)) timeout_watchdog_timer_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .kick_in(kick_in), .manual_assert_n(manual_assert_n), .monitor_enable_in(en),
        .scale_sel_0(scl[0]), .scale_sel_1(scl[1]), .fault_out_n(fault_out_n), .irq(irq));

    host_model host_model_i (.hclk(hclk), .fault_out_n(fault_out_n), .period(period), .kick_in(kick_in),
        .resets(resets));

    // ==========================================
    // Access and compare tasks
    task end_of_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task chk_rng(input string nm, input int lo, input int hi, input int g);
        compares++;
        if (g < lo || g > hi) begin
            mismatches++;
            $display("MISMATCH %s exp %0d..%0d got %0d", nm, lo, hi, g);
        end
    endtask
    task bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    // Fault is sampled on the falling edge, where it has settled
    task wait_lvl(input logic l, input int mx, output int c);
        c = 0;
        @(negedge hclk);
        while (fault_out_n !== l && c < mx) begin
            @(negedge hclk);
            c++;
        end
    endtask
    task quiet(input string nm, input int cyc);
        r0 = resets;
        repeat (cyc) @(negedge hclk);
        chk(nm, r0, resets);
    endtask

    // ==========================================
    // Tests
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        wait_lvl(1'b0, 200, n);
        chk_rng("first timeout", TO + SU - 1, TO + SU + 4, n);
        wait_lvl(1'b1, 100, n);
        chk_rng("assert width", AS - 1, AS + 1, n);
        @(posedge hclk) period <= 8;
        bus(1'b0, `INT_STAT_OFF, 0, rd);
        chk("int stat", 32'h1, rd);
        chk("hresp okay", 1'b0, hresp);
        chk("hready", 1'b1, hreadyout);
        // Mask bits enable the interrupt; all are off out of reset
        chk("irq masked", 1'b0, irq);
        bus(1'b1, `INT_MASK_OFF, 32'h3, rd);
        // Mask lands at the task's last edge, the irq flop one edge later
        repeat (2) @(negedge hclk);
        chk("irq on", 1'b1, irq);
        bus(1'b1, `INT_STAT_OFF, 32'h1, rd);
        bus(0, `INT_STAT_OFF, 0, rd);
        chk("int cleared", 32'h0, rd);
        chk("irq off", 1'b0, irq);
        bus(1'b1, 12'h010, 32'hFFFF_FFFF, rd);
        bus(0, 12'h010, 0, rd);
        chk("unmapped", 32'h0, rd);
        bus(0, `CTRL_OFF, 0, rd);
        chk("ctrl", `CTRL_RESET, rd);
        // Monitoring, scale code 0, no fault
        bus(0, `STATUS_OFF, 0, rd);
        chk("status", 32'h2, rd);
        $display("basic done");
        quiet("kicked", 200);
        @(posedge hclk) scl <= 2'h1;
        @(posedge hclk) period <= 40;
        quiet("kick at 4x", 300);
        @(posedge hclk) period <= 0;
        wait_lvl(1'b0, 200, n);
        chk_rng("4x timeout", 4 * TO - 42, 4 * TO + 4, n);
        wait_lvl(1'b1, 100, n);
        @(posedge hclk) scl <= 2'h2;
        quiet("256x", 1000);
        @(posedge hclk) scl <= 2'h3;
        quiet("code off", 300);
        @(posedge hclk) scl <= 2'h0;
        en <= 1'b0;
        quiet("enable low", 300);
        $display("scaling done");
        @(posedge hclk) manual_assert_n <= 1'b0;
        wait_lvl(1'b0, 10, n);
        chk_rng("manual", 0, 4, n);
        bus(0, `INT_STAT_OFF, 0, rd);
        chk("int manual", 1'b1, rd[`IRQ_MANUAL_BIT]);
        @(posedge hclk) manual_assert_n <= 1'b1;
        wait_lvl(1'b1, AS + 8, n);
        chk("manual release", 1'b1, fault_out_n);
        $display("manual done");
        bus(1'b1, `CTRL_OFF, 32'h1, rd);
        @(posedge hclk) en <= 1'b1;
        wait_lvl(1'b0, 40, n);
        repeat (3 * AS) @(negedge hclk);
        chk("latched", 1'b0, fault_out_n);
        bus(1'b1, `CTRL_OFF, 32'h3, rd);
        wait_lvl(1'b1, 10, n);
        chk_rng("latch clear", 0, 4, n);
        $display("latch done");
        end_of_test;
    end

    initial begin
        repeat (20000) @(posedge hclk);
        mismatches++;
        end_of_test;
    end
endmodule
